// ### core/utc_core.sv
/*
  Up/down trim counter: qualifies pulses on the three-level control pin,
  steps a saturating 8-bit count, writes it to storage on a program
  request while count enable is high and recalls it at reset and when count enable falls.
  Assumes the pin's three comparators and count enable are asynchronous.
*/
`timescale 1ns/1ps
module utc_core #(
  parameter logic [21:0] P_PROG_HOLD_CYC = utc_pkg::PROG_HOLD_CYC,
  parameter logic [21:0] P_WRITE_CYC = utc_pkg::WRITE_CYC,
  parameter logic [21:0] P_RECALL_CYC = utc_pkg::RECALL_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_ctl_prog,
  input wire logic i_ctl_high,
  input wire logic i_ctl_low,
  input wire logic i_count_en,
  output logic [7:0] o_tap_code,
  output logic o_write_busy,
  output logic o_recall_busy
);

  ////////////////////////////////////////////////////////////////////
  // Functions

  // Saturating increment for timers
  function automatic logic [21:0] utc_sat_inc(input logic [21:0] v);
    utc_sat_inc = (v == 22'h3fffff) ? v : v + 22'h000001;
  endfunction : utc_sat_inc

  // Saturating count step; up for low pulse, down for high pulse
  function automatic logic [7:0] utc_step(input logic [7:0] v, input logic up);
    if (up)
    begin
      utc_step = (v == utc_pkg::CODE_MAX) ? v : v + 8'h01;
    end
    else
    begin
      utc_step = (v == utc_pkg::CODE_MIN) ? v : v - 8'h01;
    end
  endfunction : utc_step

  ////////////////////////////////////////////////////////////////////
  // Declarations
  utc_pkg::utc_pins_t pins_raw;
  utc_pkg::utc_pins_t sync1_reg;
  utc_pkg::utc_pins_t sync2_reg;
  utc_pkg::utc_lvl_t lvl_now;
  utc_pkg::utc_lvl_t level_reg;
  utc_pkg::utc_lvl_t level_next;
  utc_pkg::utc_state_t state_reg;
  utc_pkg::utc_state_t state_next;
  logic [21:0] width_reg;
  logic [21:0] width_next;
  logic [21:0] timer_reg;
  logic [21:0] timer_next;
  logic [7:0] count_reg;
  logic [7:0] count_next;
  logic skip_reg;
  logic skip_next;
  logic cen_prev_reg;
  logic cen_prev_next;
  logic wbusy_reg;
  logic wbusy_next;
  logic rbusy_reg;
  logic rbusy_next;
  logic nvm_wr;
  logic [7:0] nvm_rd;
  logic pulse_done;

  ////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers for the pin comparators and enable
  assign pins_raw = '{prog: i_ctl_prog, high: i_ctl_high, low: i_ctl_low, cen: i_count_en};

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end
    else
    begin
      sync1_reg <= pins_raw;
      sync2_reg <= sync1_reg;
    end
  end

  // Program band wins over logic high, it also trips the high comparator
  always_comb
  begin
    if (sync2_reg.prog)
    begin
      lvl_now = utc_pkg::UTC_LVL_PROG;
    end
    else if (sync2_reg.high)
    begin
      lvl_now = utc_pkg::UTC_LVL_HIGH;
    end
    else if (sync2_reg.low)
    begin
      lvl_now = utc_pkg::UTC_LVL_LOW;
    end
    else
    begin
      lvl_now = utc_pkg::UTC_LVL_MID;
    end
  end

  // Trailing edge of a high or low excursion longer than the reject width
  assign pulse_done = (lvl_now == utc_pkg::UTC_LVL_MID)
    && (level_reg == utc_pkg::UTC_LVL_HIGH || level_reg == utc_pkg::UTC_LVL_LOW)
    && (width_reg >= utc_pkg::REJECT_CYC);

  ////////////////////////////////////////////////////////////////////
  // Next-state logic for level tracking, sequencer and counter
  always_comb
  begin
    level_next = lvl_now;
    width_next = (lvl_now == level_reg) ? utc_sat_inc(width_reg) : 22'h000000;
    state_next = state_reg;
    timer_next = timer_reg;
    count_next = count_reg;
    skip_next = skip_reg;
    cen_prev_next = sync2_reg.cen;
    nvm_wr = 1'b0;
    unique case (state_reg)
      utc_pkg::UTC_ST_RECALL:
      begin
        // Stored value lands before any adjustment is taken
        timer_next = utc_sat_inc(timer_reg);
        if (timer_reg >= P_RECALL_CYC - 22'h000001)
        begin
          count_next = nvm_rd;
          skip_next = 1'b1;
          timer_next = 22'h000000;
          state_next = utc_pkg::UTC_ST_IDLE;
        end
      end
      utc_pkg::UTC_ST_IDLE:
      begin
        if (sync2_reg.cen && !cen_prev_reg)
        begin
          skip_next = 1'b1;
        end
        else if (!sync2_reg.cen && cen_prev_reg)
        begin
          timer_next = 22'h000000;
          state_next = utc_pkg::UTC_ST_RECALL;
        end
        else if (sync2_reg.cen)
        begin
          if (level_reg == utc_pkg::UTC_LVL_PROG && lvl_now == utc_pkg::UTC_LVL_PROG
              && width_reg == P_PROG_HOLD_CYC - 22'h000001)
          begin
            // Write is issued once per program excursion
            nvm_wr = 1'b1;
            skip_next = 1'b1;
            timer_next = 22'h000000;
            state_next = utc_pkg::UTC_ST_WRITE;
          end
          else if (pulse_done)
          begin
            if (skip_reg)
            begin
              skip_next = 1'b0;
            end
            else
            begin
              count_next = utc_step(count_reg, level_reg == utc_pkg::UTC_LVL_LOW);
            end
          end
        end
      end
      utc_pkg::UTC_ST_WRITE:
      begin
        // Pulses seen here are dropped until the write ends
        timer_next = utc_sat_inc(timer_reg);
        if (timer_reg >= P_WRITE_CYC - 22'h000001)
        begin
          timer_next = 22'h000000;
          state_next = sync2_reg.cen ? utc_pkg::UTC_ST_IDLE : utc_pkg::UTC_ST_RECALL;
        end
      end
      default:
      begin
        state_next = utc_pkg::UTC_ST_RECALL;
      end
    endcase
    wbusy_next = (state_next == utc_pkg::UTC_ST_WRITE);
    rbusy_next = (state_next == utc_pkg::UTC_ST_RECALL);
  end

  // Register the state
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      level_reg <= utc_pkg::UTC_LVL_MID;
      width_reg <= 22'h000000;
      state_reg <= utc_pkg::UTC_ST_RECALL;
      timer_reg <= 22'h000000;
      count_reg <= utc_pkg::CODE_RESET;
      skip_reg <= 1'b1;
      cen_prev_reg <= 1'b0;
      wbusy_reg <= 1'b0;
      rbusy_reg <= 1'b1;
    end
    else
    begin
      level_reg <= level_next;
      width_reg <= width_next;
      state_reg <= state_next;
      timer_reg <= timer_next;
      count_reg <= count_next;
      skip_reg <= skip_next;
      cen_prev_reg <= cen_prev_next;
      wbusy_reg <= wbusy_next;
      rbusy_reg <= rbusy_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Storage cell, written with the live count
  utc_nvm u_nvm (
    .i_sys_clk(i_sys_clk),
    .i_wr_en(nvm_wr),
    .i_wr_data(count_reg),
    .o_rd_data(nvm_rd)
  );

  // Tap code is the counter itself, code 0 = first tap, 255 = last
  assign o_tap_code = count_reg;
  assign o_write_busy = wbusy_reg;
  assign o_recall_busy = rbusy_reg;

endmodule : utc_core

// ### core/utc_nvm.sv
/*
  Eight-bit non-volatile storage cell model with registered read data.
  Assumes writes come from logic on the same clock; contents are not
  touched by reset, only by a write.
*/
`timescale 1ns/1ps
module utc_nvm (
  input wire logic i_sys_clk,
  input wire logic i_wr_en,
  input wire logic [7:0] i_wr_data,
  output logic [7:0] o_rd_data
);

  ////////////////////////////////////////////////////////////////////
  // Cell keeps its value across reset, like the real array
  logic [7:0] cell_reg = utc_pkg::NVM_FACTORY;
  logic [7:0] cell_next;
  logic [7:0] rd_reg = utc_pkg::NVM_FACTORY;

  // Next value of the cell
  always_comb
  begin
    cell_next = i_wr_en ? i_wr_data : cell_reg;
  end

  // Register cell and read port
  always_ff @(posedge i_sys_clk)
  begin
    cell_reg <= cell_next;
    rd_reg <= cell_reg;
  end

  assign o_rd_data = rd_reg;

endmodule : utc_nvm

// ### core/utc_pkg.sv
/*
  Shared constants and types for the up/down trim counter with
  non-volatile storage: timing counts, reset values, pin carrier.
  Assumes a single 40 MHz system clock.
*/
package utc_pkg;

  ////////////////////////////////////////////////////////////////////
  // Widths and values
  localparam int unsigned CODE_W = 8;
  localparam int unsigned TIMER_W = 22;
  localparam logic [7:0] CODE_MIN = 8'h00;
  localparam logic [7:0] CODE_MAX = 8'hff;
  localparam logic [7:0] CODE_RESET = 8'h00;
  // Factory contents of the storage cell, mid-scale
  localparam logic [7:0] NVM_FACTORY = 8'h80;

  ////////////////////////////////////////////////////////////////////
  // Timing, figures as printed, then cycle counts
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned REJECT_WIDTH_NS = 20000;      // high/low reject width
  localparam int unsigned PROG_HOLD_NS = 200000;        // program hold time
  localparam int unsigned WRITE_TIME_NS = 100000000;    // internal write time
  localparam int unsigned RECALL_TIME_NS = 10000000;    // recall time
  // Longest times round down, least times round up
  localparam logic [21:0] REJECT_CYC = 22'(REJECT_WIDTH_NS / CLK_PERIOD_NS);
  localparam logic [21:0] PROG_HOLD_CYC = 22'((PROG_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [21:0] WRITE_CYC = 22'(WRITE_TIME_NS / CLK_PERIOD_NS);
  localparam logic [21:0] RECALL_CYC = 22'(RECALL_TIME_NS / CLK_PERIOD_NS);

  ////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {
    UTC_LVL_MID = 2'b00,
    UTC_LVL_HIGH = 2'b01,
    UTC_LVL_LOW = 2'b10,
    UTC_LVL_PROG = 2'b11
  } utc_lvl_t;

  typedef enum logic [1:0] {
    UTC_ST_RECALL = 2'b00,
    UTC_ST_IDLE = 2'b01,
    UTC_ST_WRITE = 2'b10
  } utc_state_t;

  // Comparator outputs of the control pin plus count enable
  typedef struct packed {
    logic prog;
    logic high;
    logic low;
    logic cen;
  } utc_pins_t;

endpackage : utc_pkg

// ### dv/utc_core_checker.sv
/*
  Port checker for utc_core, bound to every instance.
  Assumes the pin inputs settle well away from the clock edge.
*/
`timescale 1ns/1ps
module utc_core_checker #(
  parameter logic [21:0] P_PROG_HOLD_CYC = utc_pkg::PROG_HOLD_CYC,
  parameter logic [21:0] P_WRITE_CYC = utc_pkg::WRITE_CYC,
  parameter logic [21:0] P_RECALL_CYC = utc_pkg::RECALL_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_ctl_prog,
  input wire logic i_ctl_high,
  input wire logic i_ctl_low,
  input wire logic i_count_en,
  input wire logic [7:0] o_tap_code,
  input wire logic o_write_busy,
  input wire logic o_recall_busy
);
  logic act;
  logic dir_reg;
  logic [21:0] cnt_reg, wid_reg, pc_reg, wc_reg, rc_reg;
  logic [7:0] nv_reg;
  ////////////////////////////////////////
  // Excursion widths, busy runs, shadow of stored value
  assign act = (i_ctl_high | i_ctl_low) & ~i_ctl_prog;
  initial nv_reg = utc_pkg::NVM_FACTORY;
  always @(posedge i_sys_clk)
  begin
    cnt_reg <= act ? cnt_reg + 22'h000001 : 22'h000000;
    wid_reg <= (!act && cnt_reg != 22'h000000) ? cnt_reg : wid_reg;
    dir_reg <= act ? i_ctl_high : dir_reg; // Last direction seen
    pc_reg <= i_ctl_prog ? pc_reg + 22'h000001 : 22'h000000;
    wc_reg <= (o_write_busy && i_rst_n) ? wc_reg + 22'h000001 : 22'h000000;
    rc_reg <= (o_recall_busy && i_rst_n) ? rc_reg + 22'h000001 : 22'h000000;
    // Shadow taken on first busy cycle; unknown busy before reset leaves it alone
    if (o_write_busy && wc_reg == 22'h000000)
    begin
      nv_reg <= o_tap_code;
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_up;
    ({1'b0, o_tap_code} == {1'b0, $past(o_tap_code)} + 9'h001) && !dir_reg && wid_reg > utc_pkg::REJECT_CYC;
  endsequence
  sequence s_dn;
    ({1'b0, $past(o_tap_code)} == {1'b0, o_tap_code} + 9'h001) && dir_reg && wid_reg > utc_pkg::REJECT_CYC;
  endsequence
  property p_step;
    $changed(o_tap_code) && !$fell(o_recall_busy) |-> s_up or s_dn;
  endproperty
  a_step: assert property (p_step) else $error("tap moved without a qualified pulse");
  property p_rst;
    disable iff (1'b0) !i_rst_n |=> o_tap_code == 8'h00 && o_recall_busy;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_hold;
    o_write_busy |=> $stable(o_tap_code);
  endproperty
  a_hold: assert property (p_hold) else $error("tap moved during write");
  property p_wlen;
    $fell(o_write_busy) |-> wc_reg == P_WRITE_CYC;
  endproperty
  a_wlen: assert property (p_wlen) else $error("write length wrong");
  property p_rlen;
    $fell(o_recall_busy) |-> rc_reg >= P_RECALL_CYC && rc_reg <= P_RECALL_CYC + 22'h000002;
  endproperty
  a_rlen: assert property (p_rlen) else $error("recall length wrong");
  property p_load;
    $fell(o_recall_busy) |-> o_tap_code == nv_reg;
  endproperty
  a_load: assert property (p_load) else $error("recall gave wrong value");
  property p_prog;
    $rose(o_write_busy) |-> pc_reg >= P_PROG_HOLD_CYC;
  endproperty
  a_prog: assert property (p_prog) else $error("write without program hold");
  property p_ce;
    $fell(i_count_en) && !o_write_busy && !o_recall_busy |-> ##[1:6] o_recall_busy;
  endproperty
  a_ce: assert property (p_ce) else $error("no recall after enable fell");
endmodule : utc_core_checker

bind utc_core utc_core_checker #(.P_PROG_HOLD_CYC(P_PROG_HOLD_CYC), .P_WRITE_CYC(P_WRITE_CYC),
  .P_RECALL_CYC(P_RECALL_CYC)) u_chk (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_ctl_prog(i_ctl_prog),
  .i_ctl_high(i_ctl_high), .i_ctl_low(i_ctl_low), .i_count_en(i_count_en), .o_tap_code(o_tap_code),
  .o_write_busy(o_write_busy), .o_recall_busy(o_recall_busy));

// ### dv/utc_core_tb_top.sv
/*
  Self-checking bench for utc_core with short write and recall counts.
  Assumes the storage cell starts at its factory value.
*/
`timescale 1ns/1ps
module utc_core_tb_top;
  typedef struct {utc_pkg::utc_lvl_t lvl; logic [15:0] cyc; logic [7:0] exp;} utc_row_t;
  logic i_sys_clk = 1'b0;
  logic i_rst_n = 1'b0;
  utc_pkg::utc_pins_t pins;
  logic [7:0] tap;
  logic wbusy, rbusy;
  int num_errors = 0;
  int compares = 0;
  // First pulse after enable and after program is swallowed
  utc_row_t rows [8] = '{'{utc_pkg::UTC_LVL_LOW, 16'h1f40, 8'h80}, '{utc_pkg::UTC_LVL_LOW, 16'h1f40, 8'h81},
    '{utc_pkg::UTC_LVL_HIGH, 16'h1f40, 8'h80}, '{utc_pkg::UTC_LVL_HIGH, 16'h1f40, 8'h7f},
    '{utc_pkg::UTC_LVL_LOW, 16'h0320, 8'h7f}, '{utc_pkg::UTC_LVL_PROG, 16'h0190, 8'h7f},
    '{utc_pkg::UTC_LVL_LOW, 16'h1f40, 8'h7f}, '{utc_pkg::UTC_LVL_LOW, 16'h1f40, 8'h80}};
  always #12.5 i_sys_clk = ~i_sys_clk;
  utc_ctl_driver u_drv (.i_sys_clk(i_sys_clk), .o_pins(pins));
  utc_core #(.P_PROG_HOLD_CYC(22'h000014), .P_WRITE_CYC(22'h00000a), .P_RECALL_CYC(22'h00000a)) uut (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_ctl_prog(pins.prog), .i_ctl_high(pins.high),
    .i_ctl_low(pins.low), .i_count_en(pins.cen), .o_tap_code(tap), .o_write_busy(wbusy),
    .o_recall_busy(rbusy));
  ////////////////////////////////////////
  task automatic complete_run;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      num_errors++;
    end
  endtask : check
  // Bounded wait for both busy flags to drop
  task automatic wait_idle;
    int n;
    n = 0;
    while ((rbusy !== 1'b0 || wbusy !== 1'b0) && n < 200)
    begin
      @(posedge i_sys_clk);
      n++;
    end
    #1;
    if (rbusy !== 1'b0 || wbusy !== 1'b0)
    begin
      num_errors++;
      complete_run();
    end
  endtask : wait_idle
  ////////////////////////////////////////
  initial
  begin
    repeat (12) @(posedge i_sys_clk);
    #1;
    check(tap, utc_pkg::CODE_RESET);
    check({7'h00, rbusy}, 8'h01);
    i_rst_n = 1'b1;
    wait_idle();
    check(tap, 8'h80);
    u_drv.set_ce(1'b1);
    foreach (rows[i])
    begin
      u_drv.pulse(rows[i].lvl, rows[i].cyc);
      wait_idle();
      check(tap, rows[i].exp);
    end
    u_drv.set_ce(1'b0);
    repeat (8) @(posedge i_sys_clk);
    #1;
    check({7'h00, rbusy}, 8'h01);
    wait_idle();
    check(tap, 8'h7f);
    u_drv.pulse(utc_pkg::UTC_LVL_LOW, 16'h1f40);
    #1;
    check(tap, 8'h7f);
    // Mid-run reset keeps what was stored
    i_rst_n = 1'b0;
    repeat (3) @(posedge i_sys_clk);
    #1;
    check(tap, utc_pkg::CODE_RESET);
    i_rst_n = 1'b1;
    wait_idle();
    check(tap, 8'h7f);
    // Second program: busy flag seen mid-write, recall returns the new value
    u_drv.set_ce(1'b1);
    u_drv.pulse(utc_pkg::UTC_LVL_HIGH, 16'h1f40);
    #1;
    check(tap, 8'h7f);
    u_drv.pulse(utc_pkg::UTC_LVL_HIGH, 16'h1f40);
    #1;
    check(tap, 8'h7e);
    fork
      u_drv.pulse(utc_pkg::UTC_LVL_PROG, 16'h0190);
      begin
        // Write runs from about 23 to 32 cycles after the band is entered
        repeat (30) @(posedge i_sys_clk);
        #1;
        check({7'h00, wbusy}, 8'h01);
      end
    join
    #1;
    check({7'h00, wbusy}, 8'h00);
    u_drv.set_ce(1'b0);
    repeat (8) @(posedge i_sys_clk);
    #1;
    wait_idle();
    check(tap, 8'h7e);
    complete_run();
  end
endmodule : utc_core_tb_top

// ### dv/utc_ctl_driver.sv
/*
  Test controller model driving the control pin and count enable.
  Assumes callers pass widths in system clock cycles.
*/
`timescale 1ns/1ps
module utc_ctl_driver (
  input wire logic i_sys_clk,
  output utc_pkg::utc_pins_t o_pins
);
  // Pin floats to mid, enable pulled low
  initial o_pins = '0;
  ////////////////////////////////////////
  // One excursion, then a quiet gap at mid
  task automatic pulse(input utc_pkg::utc_lvl_t lvl, input logic [15:0] cyc);
    @(posedge i_sys_clk);
    #1;
    o_pins.prog = (lvl == utc_pkg::UTC_LVL_PROG);
    o_pins.high = (lvl == utc_pkg::UTC_LVL_HIGH) || (lvl == utc_pkg::UTC_LVL_PROG);
    o_pins.low = (lvl == utc_pkg::UTC_LVL_LOW);
    repeat (cyc) @(posedge i_sys_clk);
    #1;
    o_pins.prog = 1'b0;
    o_pins.high = 1'b0;
    o_pins.low = 1'b0;
    repeat (400) @(posedge i_sys_clk);
  endtask : pulse
  task automatic set_ce(input logic v);
    @(posedge i_sys_clk);
    #1;
    o_pins.cen = v;
  endtask : set_ce
endmodule : utc_ctl_driver
